// ===== mdc_pkg.sv
// shared constants and types for the multiplexed-address dram command port
package mdc_pkg;
  localparam int DATA_W = 18;
  localparam int HALF_W = 9;
  localparam int ADDR_W = 11;
  localparam int BANK_W = 3;
  localparam int NBANK = 8;
  localparam int WORD_AW = 6;
  localparam int MEM_AW = 9;
  localparam int LINE_D = 10;
  localparam int BEAT_W = 4;
  localparam int ROW_W = 8;
  localparam int LAT_W = 4;
  localparam int MODE_W = 8;
  // mode word fields
  localparam int MODE_CFG_LSB = 0;
  localparam int MODE_BL_LSB = 3;
  localparam int MODE_MUX_BIT = 5;
  localparam logic [2:0] CFG_MAX = 3'h4;
  // latency tables per configuration, index 0 is configuration 1; burst table indexed by the burst length field
  localparam logic [4:0][LAT_W-1:0] RL_MUX_TBL = {4'h6, 4'h4, 4'h9, 4'h7, 4'h5};
  localparam logic [4:0][LAT_W-1:0] TRC_TBL = {4'h5, 4'h3, 4'h8, 4'h6, 4'h4};
  localparam logic [3:0][BEAT_W-1:0] BL_TBL = {4'h2, 4'h8, 4'h4, 4'h2};
  // pipeline taps and reported-latency offsets relative to the programmed read latency
  localparam logic [LAT_W-1:0] RD_TAP_OFS = 4'h3;
  localparam logic [LAT_W-1:0] WR_TAP_OFS = 4'h1;
  localparam logic [LAT_W-1:0] BROADSIDE_ADJ = 4'h1;
  localparam logic [LAT_W-1:0] WR_EXTRA = 4'h1;

  typedef enum logic [1:0] {
    MDC_NOP = 2'h0,
    MDC_READ = 2'h1,
    MDC_WRITE = 2'h2,
    MDC_BANK_REFRESH_COMMAND = 2'h3
  } mdc_op_t;

  typedef enum logic [1:0] {
    MDC_ST_CMD = 2'b01,
    MDC_ST_AY = 2'b10
  } mdc_cap_st_t;

  typedef struct packed {
    mdc_op_t op;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } mdc_cmd_t;

  typedef struct packed {
    logic valid;
    logic is_wr;
    logic [BANK_W-1:0] bank;
    logic [2*ADDR_W-1:0] addr;
  } mdc_req_t;
endpackage : mdc_pkg

// ===== mdc_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
module mdc_buf2 #(
  parameter int WIDTH = 18
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic do_wr;
  logic do_rd;

  // honest flags straight from the fill count
  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data = mem[rd_ptr];
  assign do_wr = i_valid && o_ready;
  assign do_rd = o_valid && i_ready;

  // pointer and count bookkeeping
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_wr) wr_ptr <= ~wr_ptr;
      if (do_rd) rd_ptr <= ~rd_ptr;
      if (do_wr && !do_rd) count <= count + 2'h1;
      else if (do_rd && !do_wr) count <= count - 2'h1;
    end
  end

  // storage carries no reset, only the flags matter
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) mem[wr_ptr] <= i_data;
  end
endmodule : mdc_buf2

// ===== mdc_port.sv
// command, write, read and refresh logic of the multiplexed-address dram port
`timescale 1ns/100ps
module mdc_port (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ck,
  input wire mdc_pkg::mdc_cmd_t i_cmd,
  input wire logic [mdc_pkg::MODE_W-1:0] i_mode,
  input wire logic i_dk,
  input wire logic [mdc_pkg::DATA_W-1:0] i_d,
  input wire logic i_dm,
  output logic [mdc_pkg::DATA_W-1:0] o_q,
  output logic o_q_oe,
  output logic o_read_valid_flag,
  output logic [1:0] o_qk,
  output logic [1:0] o_qk_b,
  output logic [mdc_pkg::NBANK-1:0] o_bank_busy,
  output logic [mdc_pkg::ROW_W-1:0] o_refresh_row,
  output logic [mdc_pkg::LAT_W-1:0] o_read_latency,
  output logic [mdc_pkg::LAT_W-1:0] o_write_latency
);
  import mdc_pkg::*;

  logic [2:0] ck_sync;
  logic [2:0] dk_sync;
  mdc_cmd_t cmd_s1;
  mdc_cmd_t cmd_s2;
  logic [MODE_W-1:0] mode_s1;
  logic [MODE_W-1:0] mode_s2;
  logic [DATA_W-1:0] d_s1;
  logic [DATA_W-1:0] d_s2;
  logic dm_s1;
  logic dm_s2;
  logic ck_rise;
  logic ck_x;
  logic dk_x;
  logic mux_en;
  logic [2:0] cfg;
  logic [LAT_W-1:0] rl_mux;
  logic [LAT_W-1:0] row_cycle_time;
  logic [BEAT_W-1:0] bl;
  mdc_cap_st_t st;
  mdc_cmd_t pend;
  mdc_req_t new_req;
  mdc_req_t line [LINE_D];
  mdc_req_t rd_tap;
  mdc_req_t wr_tap;
  logic bank_refresh_command;
  logic [DATA_W-1:0] mem [2**MEM_AW];
  logic [BEAT_W-1:0] wr_left;
  logic [WORD_AW-1:0] wr_addr;
  logic [BANK_W-1:0] wr_bank;
  logic [BEAT_W-1:0] wr_eff_left;
  logic [WORD_AW-1:0] wr_eff_addr;
  logic [BANK_W-1:0] wr_eff_bank;
  logic wr_beat;
  logic [BEAT_W-1:0] rd_left;
  logic [WORD_AW-1:0] rd_addr;
  logic [BANK_W-1:0] rd_bank;
  logic push;
  logic pop;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  logic [ROW_W-1:0] ref_row [NBANK];
  logic [LAT_W-1:0] busy_cnt [NBANK];

  // pins from the host domain pass two flops; third stage only feeds edge detect
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ck_sync <= 3'h0;
      dk_sync <= 3'h0;
    end else begin
      ck_sync <= {ck_sync[1:0], i_ck};
      dk_sync <= {dk_sync[1:0], i_dk};
    end
  end

  // buses sampled with the same depth so they stay aligned with their clocks
  always_ff @(posedge i_clk_sys) begin
    cmd_s1 <= i_cmd;
    cmd_s2 <= cmd_s1;
    mode_s1 <= i_mode;
    mode_s2 <= mode_s1;
    d_s1 <= i_d;
    d_s2 <= d_s1;
    dm_s1 <= i_dm;
    dm_s2 <= dm_s1;
  end

  assign ck_rise = ck_sync[1] && !ck_sync[2];
  assign ck_x = ck_sync[1] ^ ck_sync[2];
  assign dk_x = dk_sync[1] ^ dk_sync[2];

  // configuration decode; illegal codes fall back to configuration 1
  assign mux_en = mode_s2[MODE_MUX_BIT];
  assign cfg = (mode_s2[MODE_CFG_LSB +: 3] > CFG_MAX) ? 3'h0 : mode_s2[MODE_CFG_LSB +: 3];
  assign rl_mux = RL_MUX_TBL[cfg];
  assign row_cycle_time = TRC_TBL[cfg];
  assign bl = BL_TBL[mode_s2[MODE_BL_LSB +: 2]];

  // reported latencies: broadside drops the extra address clock
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_read_latency <= '0;
      o_write_latency <= '0;
    end else begin
      o_read_latency <= mux_en ? rl_mux : rl_mux - BROADSIDE_ADJ;
      o_write_latency <= (mux_en ? rl_mux : rl_mux - BROADSIDE_ADJ) + WR_EXTRA;
    end
  end

  // command capture: two-crossing address in multiplexed mode, one otherwise
  always_comb begin
    new_req = '0;
    if (ck_rise) begin
      unique case (st)
        MDC_ST_CMD: begin
          if (!mux_en && (cmd_s2.op == MDC_READ || cmd_s2.op == MDC_WRITE)) begin
            new_req.valid = 1'b1;
            new_req.is_wr = (cmd_s2.op == MDC_WRITE);
            new_req.bank = cmd_s2.bank;
            new_req.addr = {{ADDR_W{1'b0}}, cmd_s2.addr};
          end
        end
        MDC_ST_AY: begin
          // second half arrives with an idle command; its op is ignored
          new_req.valid = 1'b1;
          new_req.is_wr = (pend.op == MDC_WRITE);
          new_req.bank = pend.bank;
          new_req.addr = {cmd_s2.addr, pend.addr};
        end
        default: new_req = '0;
      endcase
    end
  end

  // capture state machine holds the first half until the next true crossing
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st <= MDC_ST_CMD;
      pend <= '0;
    end else if (ck_rise) begin
      unique case (st)
        MDC_ST_CMD: begin
          if (mux_en && (cmd_s2.op == MDC_READ || cmd_s2.op == MDC_WRITE)) begin
            st <= MDC_ST_AY;
            pend <= cmd_s2;
          end
        end
        MDC_ST_AY: st <= MDC_ST_CMD;
        default: st <= MDC_ST_CMD;
      endcase
    end
  end

  // refresh needs only the bank, so it never enters the two-crossing path
  assign bank_refresh_command = ck_rise && (st == MDC_ST_CMD) && (cmd_s2.op == MDC_BANK_REFRESH_COMMAND);

  // latency line advances once per clock; later capture in mux mode adds a clock
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      for (int i = 0; i < LINE_D; i++) line[i] <= '0;
    end else if (ck_rise) begin
      line[0] <= new_req;
      for (int i = 1; i < LINE_D; i++) line[i] <= line[i-1];
    end
  end

  // read tap one clock early so the valid flag can lead by half a clock
  assign rd_tap = line[rl_mux - RD_TAP_OFS];
  assign wr_tap = line[rl_mux - WR_TAP_OFS];

  // write window: first beat may land on the opening crossing itself
  always_comb begin
    wr_eff_left = wr_left;
    wr_eff_addr = wr_addr;
    wr_eff_bank = wr_bank;
    if (ck_rise && wr_tap.valid && wr_tap.is_wr) begin
      wr_eff_left = bl;
      wr_eff_addr = wr_tap.addr[WORD_AW-1:0];
      wr_eff_bank = wr_tap.bank;
    end
  end

  assign wr_beat = dk_x && (wr_eff_left != '0);

  // a new write window simply restarts an unfinished one
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wr_left <= '0;
      wr_addr <= '0;
      wr_bank <= '0;
    end else begin
      wr_bank <= wr_eff_bank;
      wr_left <= wr_beat ? wr_eff_left - 4'h1 : wr_eff_left;
      wr_addr <= wr_beat ? wr_eff_addr + 6'h1 : wr_eff_addr;
    end
  end

  // array write; masked beats still advance the burst
  always_ff @(posedge i_clk_sys) begin
    if (wr_beat && !dm_s2) begin
      mem[{wr_eff_bank, wr_eff_addr}] <= d_s2;
    end
  end

  // read producer pushes one beat per crossing after the tap
  assign push = ck_x && (rd_left != '0) && buf_in_ready;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rd_left <= '0;
      rd_addr <= '0;
      rd_bank <= '0;
    end else if (ck_rise && rd_tap.valid && !rd_tap.is_wr) begin
      // reload right behind the last push keeps the stream gapless
      rd_left <= bl;
      rd_addr <= rd_tap.addr[WORD_AW-1:0];
      rd_bank <= rd_tap.bank;
    end else if (push) begin
      rd_left <= rd_left - 4'h1;
      rd_addr <= rd_addr + 6'h1;
    end
  end

  // buffer absorbs the half-clock gap between fetch and pin
  mdc_buf2 #(
    .WIDTH(DATA_W)
  ) u_rd_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_valid(push),
    .o_ready(buf_in_ready),
    .i_data(mem[{rd_bank, rd_addr}]),
    .o_valid(buf_out_valid),
    .i_ready(ck_x),
    .o_data(buf_out_data)
  );

  assign pop = ck_x && buf_out_valid;

  // pins change only on crossings, same cycle as the read clocks
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_q <= '0;
      o_q_oe <= 1'b0;
      o_read_valid_flag <= 1'b0;
    end else if (ck_x) begin
      o_q[HALF_W-1:0] <= pop ? buf_out_data[HALF_W-1:0] : '0;
      o_q[DATA_W-1:HALF_W] <= pop ? buf_out_data[DATA_W-1:HALF_W] : '0;
      o_q_oe <= pop;
      o_read_valid_flag <= push;
    end
  end

  // read clocks follow the input clock whenever reset is released
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_qk <= 2'h0;
      o_qk_b <= 2'h3;
    end else begin
      o_qk <= {2{ck_sync[1]}};
      o_qk_b <= {2{~ck_sync[1]}};
    end
  end

  // per-bank refresh row counters and row cycle timers run independently
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
        ref_row[b] <= '0;
        busy_cnt[b] <= '0;
      end else if (bank_refresh_command && cmd_s2.bank == BANK_W'(b)) begin
        ref_row[b] <= ref_row[b] + 8'h1;
        busy_cnt[b] <= row_cycle_time;
      end else if (ck_rise && busy_cnt[b] != '0) begin
        busy_cnt[b] <= busy_cnt[b] - 4'h1;
      end
    end
    assign o_bank_busy[b] = (busy_cnt[b] != '0);
  end

  // row used by the most recent refresh
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_refresh_row <= '0;
    end else if (bank_refresh_command) begin
      o_refresh_row <= ref_row[cmd_s2.bank];
    end
  end
endmodule : mdc_port

// ===== mdc_port_checker.sv
// concurrent checks on the dram command port outputs
`timescale 1ns/100ps
module mdc_port_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [mdc_pkg::DATA_W-1:0] o_q,
  input wire logic o_q_oe,
  input wire logic o_read_valid_flag,
  input wire logic [1:0] o_qk,
  input wire logic [1:0] o_qk_b,
  input wire logic [mdc_pkg::NBANK-1:0] o_bank_busy,
  input wire logic [mdc_pkg::ROW_W-1:0] o_refresh_row,
  input wire logic [mdc_pkg::LAT_W-1:0] o_read_latency,
  input wire logic [mdc_pkg::LAT_W-1:0] o_write_latency
);
  import mdc_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // read clocks never stall, a half period is eight system clocks
  qk_running_a: assert property (1 |-> ##[1:10] (o_qk != $past(o_qk)))
    else $error("read clock stalled");
  qk_inverse_a: assert property (o_qk_b == ~o_qk)
    else $error("read clock pair not inverse");
  qk_halves_a: assert property (o_qk[0] == o_qk[1])
    else $error("read clocks of the two halves differ");
  q_idle_zero_a: assert property (!o_q_oe |-> o_q == '0)
    else $error("read data not released while idle");
  valid_leads_a: assert property ($rose(o_q_oe) |-> o_read_valid_flag && $past(o_read_valid_flag, 4))
    else $error("valid flag not ahead of first beat");
  oe_on_edge_a: assert property ($changed(o_q_oe) |-> $changed(o_qk))
    else $error("drive enable moved off a read clock edge");
  beat_on_edge_a: assert property (o_q_oe && $changed(o_q) |-> $changed(o_qk))
    else $error("read beat moved off a read clock edge");
  valid_drop_a: assert property ($fell(o_read_valid_flag) |-> o_q_oe ##[6:10] !o_q_oe)
    else $error("valid flag not dropped with final beat");
  wl_follows_rl_a: assert property (o_read_latency != '0 && o_write_latency != '0 |->
    o_write_latency == o_read_latency + 4'h1)
    else $error("write latency not read latency plus one");
  cover property ($rose(o_read_valid_flag));
  cover property ($rose(o_bank_busy[2]));
  cover property ($changed(o_refresh_row));
endmodule : mdc_port_checker
bind mdc_port mdc_port_checker i_mdc_port_checker (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .o_q(o_q),
  .o_q_oe(o_q_oe), .o_read_valid_flag(o_read_valid_flag), .o_qk(o_qk), .o_qk_b(o_qk_b), .o_bank_busy(o_bank_busy),
  .o_refresh_row(o_refresh_row), .o_read_latency(o_read_latency), .o_write_latency(o_write_latency));

// ===== mdc_host.sv
// host controller model: command clock, commands and write beats
`timescale 1ns/100ps
module mdc_host (
  input wire logic i_clk_sys,
  output logic o_ck,
  output mdc_pkg::mdc_cmd_t o_cmd,
  output logic o_dk,
  output logic [mdc_pkg::DATA_W-1:0] o_d,
  output logic o_dm
);
  import mdc_pkg::*;
  logic [3:0] phase = 4'h0;
  // free-running command clock, sixteen system clocks per period
  // scaled to the system clock, so the configuration's frequency range is not modelled
  always @(negedge i_clk_sys) phase <= phase + 4'h1;
  assign o_ck = ~phase[3];
  assign o_dk = o_ck; // data clock edge-aligned with command clock
  initial begin
    o_cmd = '0;
    o_d = '0;
    o_dm = 1'b0;
  end
  // one command crossing, held from the fall before until the next fall
  task issue(input mdc_op_t op, input logic [BANK_W-1:0] bk, input logic [ADDR_W-1:0] ad);
    @(negedge o_ck);
    o_cmd = {op, bk, ad};
  endtask : issue
  task read(input logic [BANK_W-1:0] bk, input logic [2*ADDR_W-1:0] ad);
    issue(MDC_READ, bk, ad[ADDR_W-1:0]);
    issue(MDC_NOP, bk, ad[2*ADDR_W-1:ADDR_W]);
  endtask : read
  // beats change mid-half so each data clock edge sees settled data
  task write(input logic [BANK_W-1:0] bk, input logic [2*ADDR_W-1:0] ad,
             input logic [DATA_W-1:0] dv[4], input logic [3:0] mk, input int w);
    issue(MDC_WRITE, bk, ad[ADDR_W-1:0]);
    issue(MDC_NOP, bk, ad[2*ADDR_W-1:ADDR_W]);
    repeat (w - 1) @(posedge o_ck);
    repeat (12) @(negedge i_clk_sys);
    for (int k = 0; k < 4; k++) begin
      o_d = dv[k];
      o_dm = mk[k];
      repeat (8) @(negedge i_clk_sys);
    end
    o_d = ~o_d; // released lines show no stale beat
    o_dm = ~o_dm;
    repeat (64) @(negedge i_clk_sys); // row cycle before the next access
  endtask : write
endmodule : mdc_host

// ===== mdc_port_bench.sv
// self-checking bench for the dram command port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module mdc_port_bench;
  import mdc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [MODE_W-1:0] i_mode = 8'h28; // configuration 1, burst four, multiplexed
  logic ck, dk, dm, oe, vld;
  mdc_cmd_t cmd;
  logic [DATA_W-1:0] d, q;
  logic [1:0] qk, qk_b;
  logic [NBANK-1:0] busy;
  logic [ROW_W-1:0] row;
  logic [LAT_W-1:0] rl, wl;
  int fail_count = 0;
  int num_checks = 0;
  int drops = 0;
  logic [DATA_W-1:0] beats[$];
  logic [1:0] qk_d = 2'h0;
  logic oe_d = 1'b0;
  always #2 i_clk_sys = ~i_clk_sys;
  mdc_host i_mdc_host (.i_clk_sys(i_clk_sys), .o_ck(ck), .o_cmd(cmd), .o_dk(dk), .o_d(d), .o_dm(dm));
  mdc_port i_mdc_port (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ck(ck), .i_cmd(cmd), .i_mode(i_mode),
    .i_dk(dk), .i_d(d), .i_dm(dm), .o_q(q), .o_q_oe(oe), .o_read_valid_flag(vld), .o_qk(qk), .o_qk_b(qk_b),
    .o_bank_busy(busy), .o_refresh_row(row), .o_read_latency(rl), .o_write_latency(wl));
  // one beat per read clock crossing while the outputs drive
  always @(posedge i_clk_sys) begin
    qk_d <= qk;
    if (i_rst_b && oe && qk !== qk_d) beats.push_back(q);
    oe_d <= oe;
    if (i_rst_b && oe_d && !oe) drops++;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // bounded wait for the read collector; a timeout counts as a mismatch
  task wait_beats(input int n);
    int t;
    t = 0;
    while (beats.size() < n && t < 600) begin
      @(posedge i_clk_sys);
      t++;
    end
    if (beats.size() < n) begin
      $display("wrong value beat count expected %0d seen %0d", n, beats.size());
      fail_count++;
      wrap_up();
    end
    repeat (20) @(posedge i_clk_sys);
  endtask : wait_beats
  task test_latency;
    for (int c = 0; c < 5; c++) begin
      @(negedge i_clk_sys) i_mode = {2'h0, 1'b1, 2'h1, 3'(c)}; // burst four only
      repeat (10) @(posedge i_clk_sys);
      `CHK("read latency", RL_MUX_TBL[c], rl)
      `CHK("write latency", RL_MUX_TBL[c] + 4'h1, wl)
      @(negedge i_clk_sys) i_mode[5] = 1'b0;
      repeat (10) @(posedge i_clk_sys);
      `CHK("broadside latency", RL_MUX_TBL[c] - 4'h1, rl)
    end
    // undefined configuration code falls back to the first configuration
    @(negedge i_clk_sys) i_mode = 8'h2f;
    repeat (10) @(posedge i_clk_sys);
    `CHK("fallback latency", RL_MUX_TBL[0], rl)
    @(negedge i_clk_sys) i_mode = 8'h28;
    repeat (10) @(posedge i_clk_sys);
    $display("latency test done");
  endtask : test_latency
  task test_write_read;
    logic [DATA_W-1:0] a[4], b[4];
    for (int k = 0; k < 4; k++) begin
      a[k] = 18'h2a000 + 18'(k);
      b[k] = 18'h15000 + 18'(k);
    end
    i_mdc_host.write(3'h1, 22'h010, a, 4'h0, 6);
    i_mdc_host.write(3'h1, 22'h010, b, 4'h4, 6); // third beat masked
    i_mdc_host.write(3'h2, 22'h010, b, 4'h0, 6);
    beats.delete();
    i_mdc_host.read(3'h1, 22'h010);
    i_mdc_host.read(3'h2, 22'h010);
    wait_beats(8);
    for (int k = 0; k < 8; k++) `CHK("read beat", (k == 2) ? a[2] : b[k % 4], beats[k])
    `CHK("drive periods", 1, drops)
    `CHK("valid after burst", 1'b0, vld)
    // a write straight after a finished read stream, then read it back
    i_mdc_host.write(3'h2, 22'h010, a, 4'h0, 6);
    beats.delete();
    i_mdc_host.read(3'h2, 22'h010);
    wait_beats(4);
    for (int k = 0; k < 4; k++) `CHK("rewritten beat", a[k], beats[k])
    $display("write read test done");
  endtask : test_write_read
  task test_broadside;
    // with the mode bit low one crossing carries the whole address
    @(negedge i_clk_sys) i_mode = 8'h08;
    repeat (10) @(posedge i_clk_sys);
    beats.delete();
    i_mdc_host.issue(MDC_READ, 3'h1, 11'h010);
    i_mdc_host.issue(MDC_NOP, 3'h0, 11'h000);
    wait_beats(4);
    for (int k = 0; k < 4; k++) `CHK("flat beat", (k == 2) ? 18'h2a002 : 18'h15000 + 18'(k), beats[k])
    @(negedge i_clk_sys) i_mode = 8'h28;
    repeat (10) @(posedge i_clk_sys);
    $display("broadside test done");
  endtask : test_broadside
  task test_refresh;
    logic [ROW_W-1:0] r0;
    // full refresh period is far beyond the run; only per-bank commands are driven
    i_mdc_host.issue(MDC_BANK_REFRESH_COMMAND, 3'h2, 11'h7ff);
    i_mdc_host.issue(MDC_BANK_REFRESH_COMMAND, 3'h3, 11'h000);
    i_mdc_host.issue(MDC_NOP, 3'h0, 11'h7ff);
    `CHK("busy banks", 8'h0c, busy)
    repeat (2) i_mdc_host.issue(MDC_NOP, 3'h0, 11'h000);
    `CHK("busy banks", 8'h0c, busy)
    i_mdc_host.issue(MDC_NOP, 3'h0, 11'h7ff);
    `CHK("busy banks", 8'h08, busy)
    r0 = row;
    i_mdc_host.issue(MDC_BANK_REFRESH_COMMAND, 3'h3, 11'h000); // row cycle met
    i_mdc_host.issue(MDC_NOP, 3'h0, 11'h7ff);
    `CHK("refresh row", r0 + 8'h01, row)
    $display("refresh test done");
  endtask : test_refresh
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    test_latency();
    test_write_read();
    test_broadside();
    test_refresh();
    wrap_up();
  end
endmodule : mdc_port_bench
